/* File: logic/flash_region_protection.sv */
// Flash region protection unit: registers, command gate and reset load
//
// Notes on behaviour
// - Multi-byte parameters: most significant byte lowest-numbered
// - Parameter bytes take byte, halfword, longword access
// - Protected regions never programmed or erased
// - 32-bit map, each bit one thirty-second
// - Below 32 KB each bit covers 1 KB
// - Top bytes unused on small flash sizes
// - Index 0 holds bits 31:24, down to 3
// - Reset loads registers from configuration bytes
// - Bit 0 protects, bit 1 leaves unprotected
// - User mode: only 1-to-0 changes accepted
// - Factory mode: all bits freely writable
// - Protected alteration refused, violation flag set
// - Block erase refused if any region protected
// - Complete flag low from launch to finish
// - Two modes: user and factory
`timescale 1ns/1ns
module flash_region_protection #(
  parameter int FLASH_KB     = frp_pkg::FRP_DEF_FLASH_KB,
  parameter int SECTOR_BYTES = frp_pkg::FRP_DEF_SECTOR
) (
  input  wire logic                                    clk_sys,
  input  wire logic                                    rst,
  input  wire frp_pkg::frp_bus_req_t                   busReq,
  output logic [31:0]                                  busRdata,
  input  wire logic                                    factoryMode,
  input  wire logic [frp_pkg::FRP_CFG_BYTES-1:0][7:0]  cfgField,
  output frp_pkg::frp_flash_req_t                      flashReq,
  input  wire logic                                    flashDone,
  output logic [frp_pkg::FRP_MAP_BITS-1:0]             regionProtectBits,
  output logic                                         commandCompleteFlag,
  output logic                                         protectionViolationFlag
);

  // ****************************************************************
  // Helper functions
  // ****************************************************************
  // Number of bytes in one bus access; 0 for an undefined size code
  function automatic int accessBytes(logic [1:0] size);
    int n;
    n = 0;
    unique case (size)
      frp_pkg::FRP_SIZE_BYTE: n = 1;
      frp_pkg::FRP_SIZE_HALF: n = 2;
      frp_pkg::FRP_SIZE_WORD: n = 4;
      default:                n = 0;
    endcase
    return n;
  endfunction

  // Map slice held by protection register index idx
  function automatic logic [7:0] protByte(logic [31:0] map, int idx);
    return map[31 - 8 * idx -: 8];
  endfunction

  // One byte of the register space as software sees it
  function automatic logic [7:0] readByte(frp_pkg::frp_state_t st, logic [7:0] ba);
    logic [7:0] v;
    v = 8'h00;
    if (ba == frp_pkg::FRP_OFS_STATUS) begin
      v[frp_pkg::FRP_COMMAND_COMPLETE_FLAG_BIT]   = st.command_complete_flag;
      v[frp_pkg::FRP_PROTECTION_VIOLATION_FLAG_BIT] = st.protection_violation_flag;
    end else if (ba >= frp_pkg::FRP_OFS_CCOB_BASE &&
                 int'(ba) < int'(frp_pkg::FRP_OFS_CCOB_BASE) + frp_pkg::FRP_CCOB_COUNT) begin
      v = st.ccob[int'(ba - frp_pkg::FRP_OFS_CCOB_BASE)];
    end else if (ba >= frp_pkg::FRP_OFS_REGION_PROTECT_BITS_BASE &&
                 int'(ba) < int'(frp_pkg::FRP_OFS_REGION_PROTECT_BITS_BASE) + frp_pkg::FRP_REGION_PROTECT_BITS_COUNT) begin
      v = protByte(st.map, int'(ba - frp_pkg::FRP_OFS_REGION_PROTECT_BITS_BASE));
    end
    return v;
  endfunction

  // Reset image of the map from the configuration field
  function automatic logic [31:0] loadMap(logic [frp_pkg::FRP_CFG_BYTES-1:0][7:0] cfg);
    return {cfg[int'(frp_pkg::FRP_CFG_OFS_PROT0)], cfg[int'(frp_pkg::FRP_CFG_OFS_PROT1)],
            cfg[int'(frp_pkg::FRP_CFG_OFS_PROT2)], cfg[int'(frp_pkg::FRP_CFG_OFS_PROT3)]};
  endfunction

  // ****************************************************************
  // State
  // ****************************************************************
  frp_pkg::frp_state_t s_q;
  frp_pkg::frp_state_t s_d;

  logic        checkEn;
  logic [23:0] rangeLo;
  logic [23:0] rangeHi;
  logic        rangeViol;
  logic [7:0]  cmdCode;
  logic [23:0] cmdAddr;

  // ****************************************************************
  // Decoded command and target range
  // ****************************************************************
  // Address bytes are big endian: byte 1 carries bits 23:16
  assign cmdCode = s_q.ccob[frp_pkg::FRP_CCOB_CMD];
  assign cmdAddr = {s_q.ccob[frp_pkg::FRP_CCOB_ADDR_HI],
                    s_q.ccob[frp_pkg::FRP_CCOB_ADDR_HI + 1],
                    s_q.ccob[frp_pkg::FRP_CCOB_ADDR_HI + 2]};

  // Only commands that alter the array are screened; reads pass straight on
  always_comb begin
    checkEn = 1'b0;
    rangeLo = cmdAddr;
    rangeHi = cmdAddr;
    if (cmdCode == frp_pkg::FRP_CMD_PROGRAM) begin
      checkEn = 1'b1;
      rangeLo = cmdAddr & ~24'(frp_pkg::FRP_PROGRAM_BYTES - 1);
      rangeHi = rangeLo + 24'(frp_pkg::FRP_PROGRAM_BYTES - 1);
    end else if (cmdCode == frp_pkg::FRP_CMD_ERASE_SECTOR) begin
      checkEn = 1'b1;
      rangeLo = cmdAddr & ~24'(SECTOR_BYTES - 1);
      rangeHi = rangeLo + 24'(SECTOR_BYTES - 1);
    end else if (cmdCode == frp_pkg::FRP_CMD_ERASE_BLOCK) begin
      // The whole block is one range, so a single protected region blocks it
      checkEn = 1'b1;
      rangeLo = 24'h000000;
      rangeHi = 24'(FLASH_KB * 1024 - 1);
    end
  end

  // Range against the live map
  frp_region_check #(
    .FLASH_KB (FLASH_KB)
  ) u_check (
    .protMap   (s_q.map),
    .checkEn   (checkEn),
    .addrLo    (rangeLo),
    .addrHi    (rangeHi),
    .violation (rangeViol)
  );

  // ****************************************************************
  // Next-state logic
  // ****************************************************************
  // Bus decode, register writes, then the command sequencer
  always_comb begin
    int         nb;
    logic [7:0] ba;
    logic [7:0] db;
    int         idx;
    logic       launchReq;
    logic       clearViol;
    logic       aligned;
    nb        = accessBytes(busReq.size);
    ba        = 8'h00;
    db        = 8'h00;
    idx       = 0;
    launchReq = 1'b0;
    clearViol = 1'b0;
    aligned   = nb != 0 && (int'(busReq.addr) % (nb == 0 ? 1 : nb)) == 0;
    s_d          = s_q;
    s_d.flash.go = 1'b0;
    s_d.rdata    = 32'h00000000;

    // Reads: lowest address lands in the most significant lane
    if (busReq.sel && !busReq.write && aligned) begin
      for (int k = 0; k < 4; k++) begin
        if (k < nb) begin
          s_d.rdata[8 * (nb - 1 - k) +: 8] = readByte(s_q, 8'(busReq.addr + 8'(k)));
        end
      end
    end

    // Writes: each byte of the access goes to its own register
    if (busReq.sel && busReq.write && aligned) begin
      for (int k = 0; k < 4; k++) begin
        if (k < nb) begin
          ba = 8'(busReq.addr + 8'(k));
          db = busReq.wdata[8 * (nb - 1 - k) +: 8];
          if (ba == frp_pkg::FRP_OFS_STATUS) begin
            clearViol = clearViol | db[frp_pkg::FRP_PROTECTION_VIOLATION_FLAG_BIT];
            launchReq = launchReq | db[frp_pkg::FRP_COMMAND_COMPLETE_FLAG_BIT];
          end else if (ba >= frp_pkg::FRP_OFS_CCOB_BASE &&
                       int'(ba) < int'(frp_pkg::FRP_OFS_CCOB_BASE) + frp_pkg::FRP_CCOB_COUNT) begin
            // Parameters are frozen while a command runs
            if (s_q.command_complete_flag) begin
              s_d.ccob[int'(ba - frp_pkg::FRP_OFS_CCOB_BASE)] = db;
            end
          end else if (ba >= frp_pkg::FRP_OFS_REGION_PROTECT_BITS_BASE &&
                       int'(ba) < int'(frp_pkg::FRP_OFS_REGION_PROTECT_BITS_BASE) + frp_pkg::FRP_REGION_PROTECT_BITS_COUNT) begin
            idx = int'(ba - frp_pkg::FRP_OFS_REGION_PROTECT_BITS_BASE);
            // Writes during a running command are the software's fault, not screened
            if (factoryMode) begin
              s_d.map[31 - 8 * idx -: 8] = db;
            end else begin
              s_d.map[31 - 8 * idx -: 8] = protByte(s_q.map, idx) & db;
            end
          end
        end
      end
    end

    // Clearing comes first so a violation found this cycle still sticks
    if (clearViol) begin
      s_d.protection_violation_flag = 1'b0;
    end

    unique case (s_q.fsm)
      frp_pkg::FRP_IDLE: begin
        // A pending violation blocks launch until a separate clearing write
        if (launchReq && s_q.command_complete_flag && !s_q.protection_violation_flag) begin
          s_d.command_complete_flag = 1'b0;
          s_d.fsm  = frp_pkg::FRP_CHECK;
        end
      end
      frp_pkg::FRP_CHECK: begin
        if (rangeViol) begin
          s_d.protection_violation_flag = 1'b1;
          s_d.command_complete_flag   = 1'b1;
          s_d.fsm    = frp_pkg::FRP_IDLE;
        end else begin
          s_d.flash.go   = 1'b1;
          s_d.flash.cmd  = cmdCode;
          s_d.flash.addr = cmdAddr;
          s_d.fsm        = frp_pkg::FRP_EXEC;
        end
      end
      frp_pkg::FRP_EXEC: begin
        // Flag stays low until the array reports the end
        if (flashDone) begin
          s_d.command_complete_flag = 1'b1;
          s_d.fsm  = frp_pkg::FRP_IDLE;
        end
      end
      default: begin
        s_d.fsm = frp_pkg::FRP_IDLE;
      end
    endcase
  end

  // ****************************************************************
  // State register
  // ****************************************************************
  // The map is caught from the configuration field while reset is held
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      s_q.fsm    <= frp_pkg::FRP_IDLE;
      s_q.ccob   <= '0;
      s_q.map    <= loadMap(cfgField);
      s_q.command_complete_flag   <= 1'b1;
      s_q.protection_violation_flag <= 1'b0;
      s_q.rdata  <= 32'h00000000;
      s_q.flash  <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // ****************************************************************
  // Outputs, all straight from the state register
  // ****************************************************************
  assign busRdata                = s_q.rdata;
  assign flashReq                = s_q.flash;
  assign regionProtectBits       = s_q.map;
  assign commandCompleteFlag     = s_q.command_complete_flag;
  assign protectionViolationFlag = s_q.protection_violation_flag;

endmodule

/* File: logic/frp_region_check.sv */
// Region overlap check of an address range against the protection map
`timescale 1ns/1ns
module frp_region_check #(
  parameter int FLASH_KB = frp_pkg::FRP_DEF_FLASH_KB
) (
  input  wire logic [frp_pkg::FRP_MAP_BITS-1:0] protMap,
  input  wire logic                             checkEn,
  input  wire logic [23:0]                      addrLo,
  input  wire logic [23:0]                      addrHi,
  output logic                                  violation
);

  // ****************************************************************
  // Geometry
  // ****************************************************************
  // Large arrays split into 32 equal shares, small ones into 1 KB pieces
  localparam bit SMALL        = FLASH_KB < frp_pkg::FRP_SMALL_KB;
  localparam int REGION_BYTES = SMALL ? frp_pkg::FRP_SMALL_REGION
                                      : (FLASH_KB * 1024) / frp_pkg::FRP_MAP_BITS;
  // Bits past the array size govern nothing, so the top bytes fall idle
  localparam int ASSIGNED     = SMALL ? FLASH_KB : frp_pkg::FRP_MAP_BITS;

  // ****************************************************************
  // Overlap search
  // ****************************************************************
  // A cleared bit marks a protected region; any overlap refuses the range
  always_comb begin
    violation = 1'b0;
    for (int i = 0; i < frp_pkg::FRP_MAP_BITS; i++) begin
      if (checkEn && i < ASSIGNED && !protMap[i] &&
          int'(addrLo) < (i + 1) * REGION_BYTES && int'(addrHi) >= i * REGION_BYTES) begin
        violation = 1'b1;
      end
    end
  end

endmodule

/* File: shared/frp_pkg.sv */
// Package of constants and types for the flash region protection unit
package frp_pkg;

  // ****************************************************************
  // Register map, byte addresses on the peripheral bus
  // ****************************************************************
  localparam logic [7:0] FRP_OFS_STATUS    = 8'h00;  // flash_status_reg
  localparam logic [7:0] FRP_OFS_CCOB_BASE = 8'h04;  // command_parameter_bytes 0..B
  localparam int         FRP_CCOB_COUNT    = 12;
  localparam logic [7:0] FRP_OFS_REGION_PROTECT_BITS_BASE = 8'h10;  // region_protect_regs 0..3
  localparam int         FRP_REGION_PROTECT_BITS_COUNT    = 4;

  // ****************************************************************
  // Status register fields
  // ****************************************************************
  localparam int FRP_COMMAND_COMPLETE_FLAG_BIT   = 7;  // command_complete_flag
  localparam int FRP_PROTECTION_VIOLATION_FLAG_BIT = 4;  // protection_violation_flag

  // ****************************************************************
  // Command parameter byte layout and command codes
  // ****************************************************************
  localparam int         FRP_CCOB_CMD     = 0;  // Command code byte
  localparam int         FRP_CCOB_ADDR_HI = 1;  // Address [23:16], big endian
  localparam logic [7:0] FRP_CMD_PROGRAM  = 8'h06;
  localparam logic [7:0] FRP_CMD_ERASE_SECTOR = 8'h09;
  localparam logic [7:0] FRP_CMD_ERASE_BLOCK  = 8'h08;
  localparam int         FRP_PROGRAM_BYTES = 4;

  // ****************************************************************
  // Reset load: configuration-field offsets of protection bytes 0..3
  // ****************************************************************
  localparam logic [15:0] FRP_CFG_OFS_PROT0 = 16'h000B;
  localparam logic [15:0] FRP_CFG_OFS_PROT1 = 16'h000A;
  localparam logic [15:0] FRP_CFG_OFS_PROT2 = 16'h0009;
  localparam logic [15:0] FRP_CFG_OFS_PROT3 = 16'h0008;
  localparam int          FRP_CFG_BYTES     = 16;

  // ****************************************************************
  // Region geometry
  // ****************************************************************
  localparam int FRP_MAP_BITS      = 32;
  localparam int FRP_SMALL_KB      = 32;  // Below this, fixed-size regions
  localparam int FRP_SMALL_REGION  = 1024;
  localparam int FRP_DEF_FLASH_KB  = 128;
  localparam int FRP_DEF_SECTOR    = 1024;

  // ****************************************************************
  // Access sizes on the bus
  // ****************************************************************
  localparam logic [1:0] FRP_SIZE_BYTE = 2'h0;
  localparam logic [1:0] FRP_SIZE_HALF = 2'h1;
  localparam logic [1:0] FRP_SIZE_WORD = 2'h2;

  // ****************************************************************
  // Types
  // ****************************************************************
  typedef struct packed {
    logic        sel;
    logic        write;
    logic [1:0]  size;
    logic [7:0]  addr;
    logic [31:0] wdata;
  } frp_bus_req_t;

  typedef struct packed {
    logic        go;
    logic [7:0]  cmd;
    logic [23:0] addr;
  } frp_flash_req_t;

  typedef enum logic [2:0] {
    FRP_IDLE  = 3'b001,
    FRP_CHECK = 3'b010,
    FRP_EXEC  = 3'b100
  } frp_fsm_t;

  typedef struct packed {
    frp_fsm_t                 fsm;
    logic [FRP_CCOB_COUNT-1:0][7:0] ccob;
    logic [FRP_MAP_BITS-1:0]  map;
    logic                     command_complete_flag;
    logic                     protection_violation_flag;
    logic [31:0]              rdata;
    frp_flash_req_t           flash;
  } frp_state_t;

endpackage

/* File: tb/frp_properties.sv */
// Concurrent checks on the ports of the flash region protection unit
`timescale 1ns/1ns
module frp_properties (
  input wire logic                    clk_sys,
  input wire logic                    rst,
  input wire frp_pkg::frp_bus_req_t   busReq,
  input wire logic [31:0]             busRdata,
  input wire logic                    factoryMode,
  input wire frp_pkg::frp_flash_req_t flashReq,
  input wire logic [31:0]             regionProtectBits,
  input wire logic                    commandCompleteFlag,
  input wire logic                    protectionViolationFlag
);
  logic byteWr;

  // Byte writes, the one access size the AND, factory write and launch checks below watch
  assign byteWr = busReq.sel & busReq.write & (busReq.size == frp_pkg::FRP_SIZE_BYTE);

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (rst);

  // ****************************************************************
  // Register bus
  // ****************************************************************
  rdata_idle_a: assert property (!(busReq.sel && !busReq.write) |=> busRdata == 32'h0)
    else $error("read data left standing");
  map_read_a: assert property (busReq.sel && !busReq.write && busReq.size == frp_pkg::FRP_SIZE_WORD
    && busReq.addr == 8'h10 |=> busRdata == $past(regionProtectBits)) else $error("map read wrong");

  // ****************************************************************
  // Protection map updates
  // ****************************************************************
  user_no_raise_a: assert property (!factoryMode
    |=> (regionProtectBits & ~$past(regionProtectBits)) == 32'h0) else $error("protection lowered in user mode");
  user_and_a: assert property (!factoryMode && byteWr && busReq.addr == 8'h13
    |=> regionProtectBits[7:0] == ($past(regionProtectBits[7:0]) & $past(busReq.wdata[7:0])))
    else $error("user write not ANDed");
  factory_write_a: assert property (factoryMode && byteWr && busReq.addr == 8'h13
    |=> regionProtectBits[7:0] == $past(busReq.wdata[7:0])) else $error("factory write not stored");

  // ****************************************************************
  // Command gate
  // ****************************************************************
  launch_drop_a: assert property (byteWr && busReq.addr == 8'h00 && busReq.wdata[7] && !busReq.wdata[4]
    && commandCompleteFlag && !protectionViolationFlag |=> !commandCompleteFlag) else $error("launch not taken");
  go_busy_a: assert property (flashReq.go |-> !commandCompleteFlag && !protectionViolationFlag)
    else $error("array started while idle or faulted");
  check_out_a: assert property ($fell(commandCompleteFlag) |=> flashReq.go
    || (protectionViolationFlag && commandCompleteFlag)) else $error("check step has no outcome");
  // Any write of any size at the status offset may carry the clearing bit
  viol_hold_a: assert property (protectionViolationFlag
    && !(busReq.sel && busReq.write && busReq.addr == 8'h00) |=> protectionViolationFlag)
    else $error("violation flag lost");

  // Main scenarios reached
  cover property (flashReq.go);
  cover property ($rose(protectionViolationFlag));
  cover property ($rose(commandCompleteFlag));
endmodule

bind flash_region_protection frp_properties chk_u (
  .clk_sys                 (clk_sys),
  .rst                     (rst),
  .busReq                  (busReq),
  .busRdata                (busRdata),
  .factoryMode             (factoryMode),
  .flashReq                (flashReq),
  .regionProtectBits       (regionProtectBits),
  .commandCompleteFlag     (commandCompleteFlag),
  .protectionViolationFlag (protectionViolationFlag)
);

/* File: tb/testbench.sv */
// Self-checking bench of the flash region protection unit
`timescale 1ns/1ns
module testbench;
  logic                    clk_sys = 1'b0;
  logic                    rst = 1'b1;
  frp_pkg::frp_bus_req_t   busReq = '0;
  logic [31:0]             busRdata;
  logic                    factoryMode = 1'b0;
  logic [15:0][7:0]        cfgField = '0;
  frp_pkg::frp_flash_req_t flashReq;
  logic                    flashDone = 1'b0;
  logic [31:0]             regionProtectBits;
  logic                    commandCompleteFlag;
  logic                    protectionViolationFlag;
  logic                    rdPend = 1'b0;
  logic [31:0]             expQ[$];
  logic [31:0]             mapExp;
  logic [31:0]             rnd = 32'h0000BE29;
  int                      err_count = 0;
  int                      samples_checked = 0;

  always #5 clk_sys = ~clk_sys;

  flash_region_protection dut_u (
    .clk_sys                 (clk_sys),
    .rst                     (rst),
    .busReq                  (busReq),
    .busRdata                (busRdata),
    .factoryMode             (factoryMode),
    .cfgField                (cfgField),
    .flashReq                (flashReq),
    .flashDone               (flashDone),
    .regionProtectBits       (regionProtectBits),
    .commandCompleteFlag     (commandCompleteFlag),
    .protectionViolationFlag (protectionViolationFlag)
  );

  // ****************************************************************
  // Helpers
  // ****************************************************************
  function automatic logic [31:0] xs(input logic [31:0] v);
    v ^= v << 13;
    v ^= v >> 17;
    v ^= v << 5;
    return v;
  endfunction

  task automatic print_verdict;
    if (err_count == 0 && samples_checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_count++;
      $display("CHECK FAILED %0t: got %h want %h", $time, seen, exp);
    end
  endtask

  // One bus cycle, then an idle cycle so strobes never double up
  task automatic acc(input logic w, input logic [1:0] sz, input logic [7:0] a, input logic [31:0] d);
    busReq <= '{sel: 1'b1, write: w, size: sz, addr: a, wdata: d};
    @(posedge clk_sys);
    busReq <= '0;
    @(posedge clk_sys);
  endtask

  task automatic rd(input logic [1:0] sz, input logic [7:0] a, input logic [31:0] exp);
    expQ.push_back(exp);
    acc(1'b0, sz, a, 32'h0);
  endtask

  // Launch and wait, bounded, for either the array start or a refusal
  task automatic launch(input logic g);
    int n;
    acc(1'b1, frp_pkg::FRP_SIZE_BYTE, 8'h00, 32'h80);
    for (n = 0; n < 20; n++) begin
      @(negedge clk_sys);
      if (flashReq.go | protectionViolationFlag) break;
    end
    // A hang counts here and again in the check below; the run goes on, bounded, to its single verdict
    if (n == 20) begin
      err_count++;
    end
    chk({29'h0, flashReq.go, protectionViolationFlag, commandCompleteFlag}, {29'h0, g, ~g, ~g});
    @(posedge clk_sys);
  endtask

  // Read data stands from the taken edge; compare oldest note at the next falling edge
  always @(posedge clk_sys) rdPend <= busReq.sel & ~busReq.write;
  always @(negedge clk_sys) begin
    if (rdPend) begin
      chk(busRdata, expQ.pop_front());
    end
  end

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    for (int i = 0; i < 16; i++) begin
      rnd = xs(rnd);
      cfgField[i] = rnd[7:0];
    end
    repeat (4) @(posedge clk_sys);
    rst <= 1'b0;
    mapExp = {cfgField[11], cfgField[10], cfgField[9], cfgField[8]};
    // Look at the map away from the edge that releases reset
    @(negedge clk_sys);
    chk(regionProtectBits, mapExp);
    @(posedge clk_sys);
    rd(frp_pkg::FRP_SIZE_WORD, 8'h10, mapExp);
    for (int i = 0; i < 4; i++) begin
      rd(frp_pkg::FRP_SIZE_BYTE, 8'(16 + i), {24'h0, mapExp[31-8*i -: 8]});
    end
    rd(frp_pkg::FRP_SIZE_HALF, 8'h12, {16'h0, mapExp[15:0]});
    rd(2'h3, 8'h10, 32'h0);
    rd(frp_pkg::FRP_SIZE_BYTE, 8'h00, 32'h80);
    // Random byte writes in both modes to two registers, user mode may only clear bits
    for (int m = 0; m < 4; m++) begin
      factoryMode <= m[0];
      rnd = xs(rnd);
      acc(1'b1, frp_pkg::FRP_SIZE_BYTE, m[1] ? 8'h13 : 8'h11, {24'h0, rnd[7:0]});
      mapExp[(m[1] ? 7 : 23) -: 8] = m[0] ? rnd[7:0] : (mapExp[(m[1] ? 7 : 23) -: 8] & rnd[7:0]);
      rd(frp_pkg::FRP_SIZE_WORD, 8'h10, mapExp);
    end
    acc(1'b1, frp_pkg::FRP_SIZE_WORD, 8'h10, 32'hFFFFFFFF);
    chk(regionProtectBits, 32'hFFFFFFFF);
    acc(1'b1, frp_pkg::FRP_SIZE_WORD, 8'h04, 32'h06000100);
    for (int i = 0; i < 4; i++) begin
      rd(frp_pkg::FRP_SIZE_BYTE, 8'(4 + i), (32'h06000100 >> (24 - 8 * i)) & 32'hFF);
    end
    rd(frp_pkg::FRP_SIZE_HALF, 8'h06, 32'h00000100);
    rd(frp_pkg::FRP_SIZE_HALF, 8'h05, 32'h0);
    rd(frp_pkg::FRP_SIZE_WORD, 8'h20, 32'h0);
    // Program into an unprotected map, then a parameter write while busy
    launch(1'b1);
    chk({flashReq.cmd, flashReq.addr}, 32'h06000100);
    acc(1'b1, frp_pkg::FRP_SIZE_BYTE, 8'h05, 32'hAA);
    rd(frp_pkg::FRP_SIZE_BYTE, 8'h00, 32'h00);
    flashDone <= 1'b1;
    @(posedge clk_sys);
    flashDone <= 1'b0;
    repeat (2) @(posedge clk_sys);
    rd(frp_pkg::FRP_SIZE_BYTE, 8'h00, 32'h80);
    rd(frp_pkg::FRP_SIZE_BYTE, 8'h05, 32'h00);
    // Block erase with one protected region is refused; protect writes only once idle
    acc(1'b1, frp_pkg::FRP_SIZE_BYTE, 8'h13, 32'hFE);
    factoryMode <= 1'b0;
    acc(1'b1, frp_pkg::FRP_SIZE_BYTE, 8'h04, 32'h08);
    launch(1'b0);
    rd(frp_pkg::FRP_SIZE_BYTE, 8'h00, 32'h90);
    acc(1'b1, frp_pkg::FRP_SIZE_BYTE, 8'h00, 32'h90);
    rd(frp_pkg::FRP_SIZE_BYTE, 8'h00, 32'h80);
    // Sector erase, then program, with every region protected are refused
    acc(1'b1, frp_pkg::FRP_SIZE_WORD, 8'h10, 32'h0);
    for (int c = 0; c < 2; c++) begin
      acc(1'b1, frp_pkg::FRP_SIZE_BYTE, 8'h04, c[0] ? 32'h06 : 32'h09);
      launch(1'b0);
      acc(1'b1, frp_pkg::FRP_SIZE_BYTE, 8'h00, 32'h10);
      rd(frp_pkg::FRP_SIZE_BYTE, 8'h00, 32'h80);
    end
    // Reprogrammed configuration bytes only take hold at the next reset
    for (int i = 8; i < 12; i++) begin
      rnd = xs(rnd);
      cfgField[i] <= rnd[7:0];
    end
    rst <= 1'b1;
    repeat (3) @(posedge clk_sys);
    rst <= 1'b0;
    mapExp = {cfgField[11], cfgField[10], cfgField[9], cfgField[8]};
    @(negedge clk_sys);
    chk(regionProtectBits, mapExp);
    @(posedge clk_sys);
    rd(frp_pkg::FRP_SIZE_WORD, 8'h10, mapExp);
    rd(frp_pkg::FRP_SIZE_BYTE, 8'h00, 32'h80);
    repeat (2) @(posedge clk_sys);
    print_verdict();
  end
endmodule
